// ### bench/pics_pulse_src.sv
// Behavioural pulse source that stands in for the receiver or sensor on the pulse input.
`default_nettype none
module pics_pulse_src (
  input wire logic clk_sys,
  output logic pulseOut
);
  timeunit 1ns;
  timeprecision 1ps;
  import pics_pkg::*;
  initial pulseOut = 1'b0;
  // Sends one high pulse of the given width in microseconds between low idle gaps.
  task automatic send(input int widthUs);
    repeat (20) @(posedge clk_sys);
    pulseOut <= 1'b1;
    repeat (widthUs * TICKS_PER_US) @(posedge clk_sys);
    pulseOut <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
endmodule // pics_pulse_src
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking testbench for the pulse input capture and scaling block.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pics_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, resultValid, lowActionFire, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic signed [11:0] resultValue;
  logic [3:0] lowActionCode, firedCode;
  logic [2:0] lowActionMotors, firedMotors;
  wire pulseIn;
  int err_total, n_compared, fires;
  pics_top DUT (.clk_sys(clk_sys), .rst(rst), .pulseIn(pulseIn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .resultValue(resultValue),
    .resultValid(resultValid), .lowActionCode(lowActionCode), .lowActionMotors(lowActionMotors),
    .lowActionFire(lowActionFire), .irq(irq));
  pics_pulse_src src (.clk_sys(clk_sys), .pulseOut(pulseIn));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (lowActionFire === 1'b1)
    begin
      fires <= fires + 1;
      firedCode <= lowActionCode;
      firedMotors <= lowActionMotors;
    end
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk(n, rd, exp);
  endtask
  task automatic pulse(input int w, input int v);
    src.send(w);
    rdc("result", ADDR_RESULT, 32'(v * 2 + 1));
    chk("resultValue", 32'(resultValue), 32'(v));
    rdc("raw", ADDR_RAW, 32'(w));
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    results();
  end
  initial
  begin
    int c, n;
    logic e;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rdc("low", ADDR_LOW, 32'h3E8);
    rdc("center", ADDR_CTR, 32'h5DC);
    rdc("high", ADDR_HIGH, 32'h7D0);
    rdc("action", ADDR_ACT, 32'h0);
    rdc("config", ADDR_CFG, 32'h1);
    apb(1'b0, 8'h24, 32'h0, e);
    chk("slverr", 32'(e), 32'h1);
    wr(ADDR_LOW, 32'h0A);
    wr(ADDR_CTR, 32'h14);
    wr(ADDR_HIGH, 32'h1E);
    pulse(10, -1000);
    pulse(20, 0);
    pulse(30, 1000);
    pulse(15, -500);
    pulse(25, 500);
    pulse(5, -1000);
    pulse(40, 1000);
    chk("valid", 32'(resultValid), 32'h1);
    wr(ADDR_CFG, 32'h101);
    pulse(15, 500);
    pulse(10, 1000);
    wr(ADDR_CFG, 32'h1);
    wr(ADDR_CTR, 32'h0A);
    pulse(20, 500);
    pulse(10, 0);
    wr(ADDR_CTR, 32'h14);
    for (c = 0; c < 9; c++)
    begin
      wr(ADDR_ACT, {24'h0, 4'((c % 3) + 1), 4'(c)});
      src.send(20);
      n = fires;
      src.send(10);
      chk("fires", 32'(fires - n), 32'(c != 0));
      if (c != 0)
      begin
        chk("code", 32'(firedCode), 32'(c));
        chk("motors", 32'(firedMotors), 32'(1 << (c % 3)));
      end
    end
    rdc("status", ADDR_STAT, 32'h7);
    chk("irq", 32'(irq), 32'h0);
    wr(ADDR_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'(irq), 32'h1);
    wr(ADDR_STAT, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'(irq), 32'h0);
    rdc("status", ADDR_STAT, 32'h5);
    wr(ADDR_ACT, 32'h11);
    src.send(20);
    wr(ADDR_CFG, 32'h0);
    n = fires;
    src.send(10);
    rdc("result", ADDR_RESULT, 32'h0);
    chk("valid", 32'(resultValid), 32'h0);
    chk("fires", 32'(fires - n), 32'h0);
    for (c = 0; c < 8; c++)
    begin
      wr(ADDR_CFG, 32'(c));
      rdc("mode", ADDR_CFG, 32'(c));
    end
    results();
  end
endmodule // tb_top
`default_nettype wire

// ### hw/pics_pkg.sv
// Package of constants and types for the pulse input capture and scaling block.
package pics_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int US_NS = 1000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int TICKS_PER_US = US_NS / CLK_NS;
  localparam int PULSE_MIN_US = 500;
  localparam int PULSE_MAX_US = 3000;
  localparam int FRAME_MAX_US = 20000;
  localparam logic [15:0] LOW_RST = 16'h03E8;
  localparam logic [15:0] CTR_RST = 16'h05DC;
  localparam logic [15:0] HIGH_RST = 16'h07D0;
  localparam logic [7:0] ACT_RST = 8'h00;
  localparam logic [2:0] MODE_RST = 3'h1;
  localparam logic POL_RST = 1'b0;
  localparam logic signed [11:0] FULL_SCALE = 12'sh3E8;
  localparam logic [7:0] ADDR_RESULT = 8'h00;
  localparam logic [7:0] ADDR_LOW = 8'h04;
  localparam logic [7:0] ADDR_CTR = 8'h08;
  localparam logic [7:0] ADDR_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_ACT = 8'h10;
  localparam logic [7:0] ADDR_CFG = 8'h14;
  localparam logic [7:0] ADDR_RAW = 8'h18;
  localparam logic [7:0] ADDR_STAT = 8'h1C;
  localparam logic [7:0] ADDR_MASK = 8'h20;
  localparam int ST_NEW = 0;
  localparam int ST_MIN = 1;
  localparam int ST_ERR = 2;
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000, MODE_WIDTH = 3'b001, MODE_FREQ = 3'b010, MODE_DUTY = 3'b011,
    MODE_MAG = 3'b100, MODE_BATT = 3'b101, MODE_COUNT = 3'b110, MODE_FLOW = 3'b111
  } pics_mode_type;
endpackage
`default_nettype wire

// ### hw/pics_scale.sv
// Linear scaler from a raw capture to a signed range of plus and minus one thousand.
`default_nettype none
module pics_scale (
  input wire logic [15:0] raw,
  input wire logic [15:0] lowBound,
  input wire logic [15:0] centerValue,
  input wire logic [15:0] highBound,
  input wire logic invert,
  output logic signed [11:0] scaled
);
  import pics_pkg::*;
  function automatic logic [10:0] ratio(input logic [15:0] num, input logic [15:0] den);
    logic [25:0] prod;
    logic [25:0] quo;
    prod = {10'h000, num} * 26'd1000;
    quo = (den == 16'h0000) ? 26'd0 : prod / {10'h000, den};
    ratio = (quo > 26'd1000) ? 11'd1000 : quo[10:0];
  endfunction
  wire upper = raw >= centerValue;
  wire [15:0] upNum = (raw >= highBound) ? highBound - centerValue : raw - centerValue;
  wire [15:0] dnNum = (raw <= lowBound) ? centerValue - lowBound : centerValue - raw;
  wire [10:0] upMag = ratio(upNum, highBound - centerValue);
  wire [10:0] dnMag = ratio(dnNum, centerValue - lowBound);
  // Center equal to the low bound leaves only the upper half in use.
  wire signed [11:0] plain = upper ? $signed({1'b0, upMag}) : -$signed({1'b0, dnMag});
  assign scaled = invert ? -plain : plain;
endmodule // pics_scale
`default_nettype wire

// ### hw/pics_top.sv
// Top of the pulse input capture and scaling block with its APB register file.
`default_nettype none
module pics_top #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pulseIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic signed [11:0] resultValue,
  output logic resultValid,
  output logic [3:0] lowActionCode,
  output logic [2:0] lowActionMotors,
  output logic lowActionFire,
  output logic irq
);
  import pics_pkg::*;
  localparam int TICK_W = $clog2(TICKS_PER_US);
  logic [15:0] pulseLowBound;
  logic [15:0] pulseCenterValue;
  logic [15:0] pulseHighBound;
  logic [7:0] pulseLowBoundAction;
  pics_mode_type pulseInputModeSelect;
  logic pulseResultPolarity;
  logic [2:0] status;
  logic [2:0] mask;
  logic pinPrev;
  logic [TICK_W-1:0] tick;
  logic [WIDTH-1:0] highUs;
  logic [WIDTH-1:0] periodUs;
  logic capDone;
  logic [15:0] rawHeld;
  logic rangeErr;
  logic signed [11:0] scaledNow;
  logic atLowPrev;

  wire enabled = pulseInputModeSelect != MODE_OFF;
  wire rise = pulseIn & ~pinPrev;
  wire fall = ~pulseIn & pinPrev;
  wire usTick = tick == TICK_W'(TICKS_PER_US - 1);
  wire [WIDTH-1:0] periodNext = periodUs + WIDTH'(1);
  wire [WIDTH-1:0] highNext = highUs + WIDTH'(1);
  // Width mode closes on the falling edge; period based modes close on the rising edge.
  wire widthMode = pulseInputModeSelect == MODE_WIDTH;
  wire capEvent = enabled && (widthMode ? fall : rise);
  wire [31:0] dutyProd = {16'h0000, highUs[15:0]} * 32'd1000;
  wire [15:0] dutyVal = (periodUs == '0) ? 16'h0000 : 16'(dutyProd / {16'h0000, periodUs[15:0]});
  wire [31:0] freqQuot = (periodUs == '0) ? 32'd0 : 32'd1000000 / {16'h0000, periodUs[15:0]};
  wire [15:0] freqVal = 16'(freqQuot);
  wire [15:0] captured =
    (pulseInputModeSelect == MODE_DUTY) ? dutyVal :
    (pulseInputModeSelect == MODE_FREQ || pulseInputModeSelect == MODE_FLOW) ? freqVal :
    highUs[15:0];
  wire widthBad = widthMode && (highUs < WIDTH'(PULSE_MIN_US) || highUs > WIDTH'(PULSE_MAX_US));
  wire atLow = resultValid && rawHeld <= pulseLowBound;
  wire lowHit = atLow && !atLowPrev && enabled;
  wire [2:0] events = {capDone && rangeErr, lowHit, capDone};
  wire access = psel && penable;
  wire wrEn = access && pwrite;
  wire known = paddr <= ADDR_MASK && paddr[1:0] == 2'b00;
  wire [2:0] motorSel = pulseLowBoundAction[7:4] == 4'h1 ? 3'b001 :
                        pulseLowBoundAction[7:4] == 4'h2 ? 3'b010 :
                        pulseLowBoundAction[7:4] == 4'h3 ? 3'b100 : 3'b000;

  pics_scale u_scale (
    .raw(rawHeld),
    .lowBound(pulseLowBound),
    .centerValue(pulseCenterValue),
    .highBound(pulseHighBound),
    .invert(pulseResultPolarity),
    .scaled(scaledNow)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pinPrev <= 1'b0;
      tick <= '0;
      highUs <= '0;
      periodUs <= '0;
      capDone <= 1'b0;
      rawHeld <= 16'h0000;
      rangeErr <= 1'b0;
    end
    else
    begin
      pinPrev <= pulseIn;
      // The edge is seen one clock late, so the microsecond count restarts at one.
      tick <= rise ? TICK_W'(1) : usTick ? '0 : tick + TICK_W'(1);
      capDone <= capEvent;
      if (capEvent)
      begin
        rawHeld <= captured;
        rangeErr <= widthBad;
      end
      if (rise)
      begin
        periodUs <= '0;
        highUs <= '0;
      end
      else if (usTick)
      begin
        if (periodNext != '0)
          periodUs <= periodNext;
        if (pulseIn && highNext != '0)
          highUs <= highNext;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      resultValue <= 12'sh000;
      resultValid <= 1'b0;
      atLowPrev <= 1'b0;
      lowActionFire <= 1'b0;
      lowActionCode <= 4'h0;
      lowActionMotors <= 3'b000;
    end
    else
    begin
      resultValid <= enabled && (resultValid || capDone);
      resultValue <= enabled ? scaledNow : 12'sh000;
      atLowPrev <= atLow;
      lowActionFire <= lowHit && pulseLowBoundAction[3:0] != 4'h0;
      if (lowHit)
      begin
        lowActionCode <= pulseLowBoundAction[3:0];
        lowActionMotors <= motorSel;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pulseLowBound <= LOW_RST;
      pulseCenterValue <= CTR_RST;
      pulseHighBound <= HIGH_RST;
      pulseLowBoundAction <= ACT_RST;
      pulseInputModeSelect <= pics_mode_type'(MODE_RST);
      pulseResultPolarity <= POL_RST;
      status <= 3'b000;
      mask <= 3'b000;
    end
    else
    begin
      if (wrEn && paddr == ADDR_LOW)
        pulseLowBound <= pwdata[15:0];
      if (wrEn && paddr == ADDR_CTR)
        pulseCenterValue <= pwdata[15:0];
      if (wrEn && paddr == ADDR_HIGH)
        pulseHighBound <= pwdata[15:0];
      if (wrEn && paddr == ADDR_ACT)
        pulseLowBoundAction <= pwdata[7:0];
      if (wrEn && paddr == ADDR_CFG)
      begin
        pulseInputModeSelect <= pics_mode_type'(pwdata[2:0]);
        pulseResultPolarity <= pwdata[8];
      end
      if (wrEn && paddr == ADDR_MASK)
        mask <= pwdata[2:0];
      // A new event wins over a write-one clear in the same cycle.
      status <= (status & ~((wrEn && paddr == ADDR_STAT) ? pwdata[2:0] : 3'b000)) | events;
    end
  end

  wire [31:0] readMux =
    (paddr == ADDR_RESULT) ? {{19{resultValue[11]}}, resultValue, resultValid} :
    (paddr == ADDR_LOW) ? {16'h0000, pulseLowBound} :
    (paddr == ADDR_CTR) ? {16'h0000, pulseCenterValue} :
    (paddr == ADDR_HIGH) ? {16'h0000, pulseHighBound} :
    (paddr == ADDR_ACT) ? {24'h000000, pulseLowBoundAction} :
    (paddr == ADDR_CFG) ? {23'h000000, pulseResultPolarity, 5'h00, pulseInputModeSelect} :
    (paddr == ADDR_RAW) ? {16'h0000, rawHeld} :
    (paddr == ADDR_STAT) ? {29'h00000000, status} :
    (paddr == ADDR_MASK) ? {29'h00000000, mask} : 32'h00000000;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= readMux;
  end

  assign pready = 1'b1;
  assign pslverr = access && !known;
  assign irq = |(status & mask);

  a_low_fires: assert property (@(posedge clk_sys) disable iff (rst)
    lowHit && pulseLowBoundAction[3:0] != 4'h0 |=> lowActionFire) else $error("low action missed");
  a_off_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !enabled |=> !resultValid && !lowActionFire) else $error("disabled input active");
  a_range_held: assert property (@(posedge clk_sys) disable iff (rst)
    resultValue <= FULL_SCALE && resultValue >= -FULL_SCALE) else $error("result out of range");
  a_low_maps: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && rawHeld == pulseLowBound && pulseCenterValue > pulseLowBound && !pulseResultPolarity
    && $stable(rawHeld) && $stable(pulseLowBound) && $stable(pulseResultPolarity) && $stable(enabled)
    |=> resultValue == -FULL_SCALE) else $error("low bound not minus full");
  a_ctr_zero: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && rawHeld == pulseCenterValue && $stable(rawHeld) && $stable(pulseCenterValue)
    |=> resultValue == 12'sh000) else $error("center not zero");
  a_high_maps: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && rawHeld == pulseHighBound && pulseHighBound > pulseCenterValue && !pulseResultPolarity
    && $stable(rawHeld) && $stable(pulseHighBound) && $stable(pulseResultPolarity)
    |=> resultValue == FULL_SCALE) else $error("high bound not plus full");

  a_pol_negate: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && pulseResultPolarity && rawHeld == pulseLowBound && pulseCenterValue > pulseLowBound
    |=> resultValue == FULL_SCALE) else $error("polarity not applied");

  a_pos_only: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && pulseCenterValue == pulseLowBound && !pulseResultPolarity && $stable(pulseCenterValue)
    && $stable(pulseLowBound) && $stable(pulseResultPolarity) |=> resultValue >= 12'sh000)
    else $error("negative with center at low");
  a_event_wins: assert property (@(posedge clk_sys) disable iff (rst)
    capDone |=> status[ST_NEW]) else $error("event lost on clear");

  a_fire_single: assert property (@(posedge clk_sys) disable iff (rst)
    lowActionFire |=> !lowActionFire) else $error("action pulse too long");

  a_fire_code: assert property (@(posedge clk_sys) disable iff (rst)
    lowActionFire |-> lowActionCode == $past(pulseLowBoundAction[3:0]) && lowActionCode != 4'h0)
    else $error("action code wrong");

  a_motor_one: assert property (@(posedge clk_sys) disable iff (rst)
    lowActionFire && $past(pulseLowBoundAction[7:4]) == 4'h1 |-> lowActionMotors == 3'b001)
    else $error("motor one not selected");

  a_motor_two: assert property (@(posedge clk_sys) disable iff (rst)
    lowActionFire && $past(pulseLowBoundAction[7:4]) == 4'h2 |-> lowActionMotors == 3'b010)
    else $error("motor two not selected");

  a_motor_three: assert property (@(posedge clk_sys) disable iff (rst)
    lowActionFire && $past(pulseLowBoundAction[7:4]) == 4'h3 |-> lowActionMotors == 3'b100)
    else $error("motor three not selected");

  a_low_reset: assert property (@(posedge clk_sys)
    rst |=> pulseLowBound == LOW_RST) else $error("low bound reset wrong");

  a_ctr_reset: assert property (@(posedge clk_sys)
    rst |=> pulseCenterValue == CTR_RST) else $error("center reset wrong");

  a_high_reset: assert property (@(posedge clk_sys)
    rst |=> pulseHighBound == HIGH_RST) else $error("high bound reset wrong");

  a_act_reset: assert property (@(posedge clk_sys)
    rst |=> pulseLowBoundAction == ACT_RST) else $error("action reset wrong");

  a_pol_reset: assert property (@(posedge clk_sys)
    rst |=> pulseResultPolarity == POL_RST) else $error("polarity reset wrong");

  a_mode_reset: assert property (@(posedge clk_sys)
    rst |=> pulseInputModeSelect == pics_mode_type'(MODE_RST)) else $error("mode reset wrong");

  a_valid_rise: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(resultValid) |-> $past(capDone)) else $error("valid without capture");

  a_sat_low: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && rawHeld < pulseLowBound && pulseCenterValue > pulseLowBound && !pulseResultPolarity
    |=> resultValue == -FULL_SCALE) else $error("low side not saturated");

  a_sat_high: assert property (@(posedge clk_sys) disable iff (rst)
    enabled && rawHeld > pulseHighBound && pulseHighBound > pulseCenterValue && !pulseResultPolarity
    |=> resultValue == FULL_SCALE) else $error("high side not saturated");

  a_off_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !enabled |=> resultValue == 12'sh000) else $error("disabled input has value");

  a_width_flag: assert property (@(posedge clk_sys) disable iff (rst)
    capDone && rangeErr |=> status[ST_ERR]) else $error("width error not flagged");

  a_low_flag: assert property (@(posedge clk_sys) disable iff (rst)
    lowHit |=> status[ST_MIN]) else $error("low bound event not flagged");
endmodule // pics_top
`default_nettype wire
